// *** isp_defines.svh ***
// Purpose: constants of the serial programming command decoder
// Assumes: core clock of 20 MHz
// Notes: offsets are APB byte addresses
// Function
// - c1 00 instructions load byte four into page buffer slot byte3[7:5].
// - c2 instructions with byte2[7:6] zero commit the page buffer at page a:b from bytes 2 and 3.
// - 58 00 returns the six lock bits in byte four, zero meaning programmed.
// - ac 111x writes the low six bits of byte four as the new lock bits.
// - ac a0, ac a8, ac a4 write low, high and extended fuse (two bits).
// - 50 00, 58 08, 50 08 return low, high and extended fuse in byte four.
// - f0 00 returns the pending flag in bit 0 of byte four.
// - don't care bit positions are never decoded.
// - bits are sampled at rising and changed at falling serial clock edges.
// - during byte three of programming enable the byte 53 is echoed.
// - a page commit alters only the slots that were loaded.
`ifndef ISP_DEFINES_SVH
`define ISP_DEFINES_SVH
`define CLK_PERIOD_NS   50
`define T_WD_EEPROM_NS  9000000
`define T_WD_FUSE_NS    4500000
`define EE_WAIT_CYC  ((`T_WD_EEPROM_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FUSE_WAIT_CYC ((`T_WD_FUSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_FUSE        12'h008
`define OFS_LOCK        12'h00c
`define CTRL_EN_BIT     0
`define ST_PROG_BIT     0
`define ST_PEND_BIT     1
`define ST_OVF_BIT      2
`define OP_LOAD_PAGE    8'hc1
`define OP_WRITE_PAGE   8'hc2
`define OP_WRITE_MISC   8'hac
`define OP_READ_LF      8'h50
`define OP_READ_HL      8'h58
`define OP_POLL         8'hf0
`define B2_ZERO         8'h00
`define B2_HIGH         8'h08
`define B2_PROG_EN      8'h53
`define B2_FUSE_LOW     8'ha0
`define B2_FUSE_HIGH    8'ha8
`define B2_FUSE_EXT     8'ha4
`define FUSE_RESET      8'hff
`define LOCK_RESET      6'h3f
`define FIFO_DEPTH      4
`define INSTR_BITS      32
`endif

// *** isp_pkg.sv ***
// Purpose: types of the serial programming command decoder
// Assumes: nothing
// Notes: none
package isp_pkg;
    typedef enum logic [1:0] {
        EX_IDLE,
        EX_COMMIT,
        EX_WAIT
    } exec_state_t;
    typedef logic [31:0] instr_t;
endpackage : isp_pkg

// *** isp_fifo.sv ***
// Purpose: small flip-flop fifo with valid/ready on both sides
// Assumes: single clock
// Notes: depth must be a power of two
`timescale 1ns/10ps
module isp_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule : isp_fifo

// *** isp_decoder.sv ***
// Purpose: device side decoder of four-byte serial programming instructions
// Assumes: link pins asynchronous to CORE_CLK_I, serial clock much slower
// Notes: write commands are queued, reads and polls are answered in line
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/10ps
`include "isp_defines.svh"
module isp_decoder #(
    parameter int EE_WAIT   = `EE_WAIT_CYC,
    parameter int FUSE_WAIT = `FUSE_WAIT_CYC
) (
    input  wire logic        CORE_CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        SCK_I,
    input  wire logic        MOSI_I,
    input  wire logic        PROG_RESET_N_I,
    output logic             MISO_O,
    output logic             EE_WE_O,
    output logic [10:0]      EE_ADDR_O,
    output logic [7:0]       EE_DATA_O,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR
);
    import isp_pkg::*;

    logic [2:0]  sck_s_q;
    logic [1:0]  mosi_s_q;
    logic [1:0]  rst_s_q;
    logic        sck_rise;
    logic        sck_fall;
    logic        link_on;
    logic [31:0] in_sr_q;
    logic [5:0]  bit_cnt_q;
    logic [15:0] out_sr_q;
    logic        miso_q;
    logic        prog_en_q;
    logic        en_q;
    logic        ovf_q;
    logic [7:0]  fuse_lo_q;
    logic [7:0]  fuse_hi_q;
    logic [7:0]  fuse_ex_q;
    logic [5:0]  lock_q;
    logic [7:0]  pg_data_q [8];
    logic [7:0]  pg_mask_q;
    logic [7:0]  pg_addr_q;
    logic [2:0]  cm_idx_q;
    logic [17:0] wait_q;
    exec_state_t st_q;
    logic        pending;
    logic [31:0] word_now;
    logic        word_done;
    logic        is_write_kind;
    logic        fifo_rdy;
    logic        ex_valid;
    logic        ex_pop;
    instr_t      ex_word;
    logic        apb_acc;
    logic        apb_hit;

    // read answer for bytes 1 and 2, don't care bits never looked at
    function automatic logic [7:0] read_answer(input logic [7:0] b1,
                                               input logic [7:0] b2,
                                               input logic       busy);
        logic [7:0] r;
        r = 8'h00;
        if (b1 == `OP_READ_HL && b2 == `B2_ZERO) begin
            r = {2'b11, lock_q};
        end else if (b1 == `OP_READ_LF && b2 == `B2_ZERO) begin
            r = fuse_lo_q;
        end else if (b1 == `OP_READ_HL && b2 == `B2_HIGH) begin
            r = fuse_hi_q;
        end else if (b1 == `OP_READ_LF && b2 == `B2_HIGH) begin
            r = fuse_ex_q;
        end else if (b1 == `OP_POLL && b2 == `B2_ZERO) begin
            r = {7'h00, busy};
        end
        return r;
    endfunction : read_answer

    // pins pass two flops; the third only serves edge detection
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            sck_s_q  <= 3'h0;
            mosi_s_q <= 2'h0;
            rst_s_q  <= 2'h3;
        end else begin
            sck_s_q  <= {sck_s_q[1:0], SCK_I};
            mosi_s_q <= {mosi_s_q[0], MOSI_I};
            rst_s_q  <= {rst_s_q[0], PROG_RESET_N_I};
        end
    end

    assign link_on  = en_q && !rst_s_q[1];
    assign sck_rise = link_on && sck_s_q[1] && !sck_s_q[2];
    assign sck_fall = link_on && !sck_s_q[1] && sck_s_q[2];
    assign word_now = {in_sr_q[30:0], mosi_s_q[1]};
    assign word_done = sck_rise && bit_cnt_q == 6'd31;

    // shift in msb first, four bytes per instruction
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            in_sr_q   <= 32'h0;
            bit_cnt_q <= 6'h0;
        end else if (!link_on) begin
            bit_cnt_q <= 6'h0;
        end else if (sck_rise) begin
            in_sr_q   <= word_now;
            bit_cnt_q <= (bit_cnt_q == 6'd31) ? 6'h0 : bit_cnt_q + 6'd1;
        end
    end

    // answer bytes 3 and 4 loaded when byte 2 is complete
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            out_sr_q <= 16'h0;
            miso_q   <= 1'b0;
        end else if (!link_on) begin
            out_sr_q <= 16'h0;
            miso_q   <= 1'b0;
        end else if (sck_rise && bit_cnt_q == 6'd15) begin
            if (word_now[15:8] == `OP_WRITE_MISC &&
                word_now[7:0] == `B2_PROG_EN) begin
                out_sr_q <= {`B2_PROG_EN, 8'h00};
            end else begin
                out_sr_q <= {8'h00, read_answer(word_now[15:8],
                                                word_now[7:0], pending)};
            end
        end else if (sck_fall && bit_cnt_q >= 6'd16) begin
            miso_q   <= out_sr_q[15];
            out_sr_q <= {out_sr_q[14:0], 1'b0};
        end else if (sck_fall && bit_cnt_q == 6'd0) begin
            miso_q   <= 1'b0;
        end
    end
    assign MISO_O = miso_q;

    // programming enable holds only while the reset pin stays low
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            prog_en_q <= 1'b0;
        end else if (!link_on) begin
            prog_en_q <= 1'b0;
        end else if (word_done && word_now[31:24] == `OP_WRITE_MISC &&
                     word_now[23:16] == `B2_PROG_EN) begin
            prog_en_q <= 1'b1;
        end
    end

    // only instructions that change state are queued
    assign is_write_kind = prog_en_q && (word_now[31:24] == `OP_LOAD_PAGE ||
        word_now[31:24] == `OP_WRITE_PAGE ||
        (word_now[31:24] == `OP_WRITE_MISC &&
         word_now[23:16] != `B2_PROG_EN));

    isp_fifo #(
        .WIDTH (`INSTR_BITS),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (CORE_CLK_I),
        .rst_i       (SYS_RST_I),
        .in_valid_i  (word_done && is_write_kind),
        .in_ready_o  (fifo_rdy),
        .in_data_i   (word_now),
        .out_valid_o (ex_valid),
        .out_ready_i (ex_pop),
        .out_data_o  (ex_word)
    );

    // executor stalls while an operation runs, so the queue really fills
    assign ex_pop  = ex_valid && st_q == EX_IDLE;
    // queued writes count as busy, so no poll falls between two of them
    assign pending = st_q != EX_IDLE || ex_valid;

    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            st_q     <= EX_IDLE;
            wait_q   <= 18'h0;
            cm_idx_q <= 3'h0;
        end else begin
            unique case (st_q)
                EX_IDLE: begin
                    if (ex_pop && ex_word[31:24] == `OP_WRITE_PAGE &&
                        ex_word[23:22] == 2'b00) begin
                        st_q     <= EX_COMMIT;
                        cm_idx_q <= 3'h0;
                    end else if (ex_pop &&
                                 ex_word[31:24] == `OP_WRITE_MISC &&
                                 (ex_word[23:21] == 3'b111 ||
                                  ex_word[23:16] == `B2_FUSE_LOW ||
                                  ex_word[23:16] == `B2_FUSE_HIGH ||
                                  ex_word[23:16] == `B2_FUSE_EXT)) begin
                        st_q   <= EX_WAIT;
                        wait_q <= 18'(FUSE_WAIT);
                    end
                end
                EX_COMMIT: begin
                    cm_idx_q <= cm_idx_q + 3'h1;
                    if (cm_idx_q == 3'h7) begin
                        st_q   <= EX_WAIT;
                        wait_q <= 18'(EE_WAIT);
                    end
                end
                EX_WAIT: begin
                    wait_q <= wait_q - 18'h1;
                    if (wait_q <= 18'h1) begin
                        st_q <= EX_IDLE;
                    end
                end
            endcase
        end
    end

    // page buffer with a loaded-slot mask
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            pg_mask_q <= 8'h0;
            pg_addr_q <= 8'h0;
            for (int i = 0; i < 8; i++) begin
                pg_data_q[i] <= 8'h0;
            end
        end else if (ex_pop && ex_word[31:24] == `OP_LOAD_PAGE &&
                     ex_word[23:16] == 8'h00) begin
            pg_data_q[ex_word[15:13]] <= ex_word[7:0];
            pg_mask_q[ex_word[15:13]] <= 1'b1;
        end else if (ex_pop && ex_word[31:24] == `OP_WRITE_PAGE) begin
            pg_addr_q <= {ex_word[18:16], ex_word[15:11]};
        end else if (st_q == EX_COMMIT && cm_idx_q == 3'h7) begin
            pg_mask_q <= 8'h0;
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            EE_WE_O   <= 1'b0;
            EE_ADDR_O <= 11'h0;
            EE_DATA_O <= 8'h0;
        end else begin
            EE_WE_O   <= st_q == EX_COMMIT && pg_mask_q[cm_idx_q];
            EE_ADDR_O <= {pg_addr_q, cm_idx_q};
            EE_DATA_O <= pg_data_q[cm_idx_q];
        end
    end

    // fuses and lock bits, zero means programmed
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            fuse_lo_q <= `FUSE_RESET;
            fuse_hi_q <= `FUSE_RESET;
            fuse_ex_q <= `FUSE_RESET;
            lock_q    <= `LOCK_RESET;
        end else if (ex_pop && ex_word[31:24] == `OP_WRITE_MISC) begin
            if (ex_word[23:21] == 3'b111) begin
                lock_q <= ex_word[5:0];
            end else if (ex_word[23:16] == `B2_FUSE_LOW) begin
                fuse_lo_q <= ex_word[7:0];
            end else if (ex_word[23:16] == `B2_FUSE_HIGH) begin
                fuse_hi_q <= ex_word[7:0];
            end else if (ex_word[23:16] == `B2_FUSE_EXT) begin
                fuse_ex_q <= {6'h3f, ex_word[1:0]};
            end
        end
    end

    // apb slave, zero wait states, unmapped answers with pslverr
    assign apb_acc = PSEL && PENABLE;
    assign apb_hit = PADDR == `OFS_CTRL || PADDR == `OFS_STATUS ||
                     PADDR == `OFS_FUSE || PADDR == `OFS_LOCK;
    assign PREADY  = 1'b1;
    assign PSLVERR = apb_acc && !apb_hit;

    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            en_q <= 1'b1;
        end else if (apb_acc && PWRITE && PADDR == `OFS_CTRL) begin
            en_q <= PWDATA[`CTRL_EN_BIT];
        end
    end

    // a drop in the same cycle as the clear keeps the flag set
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ovf_q <= 1'b0;
        end else if (word_done && is_write_kind && !fifo_rdy) begin
            ovf_q <= 1'b1;
        end else if (apb_acc && PWRITE && PADDR == `OFS_STATUS &&
                     PWDATA[`ST_OVF_BIT]) begin
            ovf_q <= 1'b0;
        end
    end

    always_comb begin
        PRDATA = 32'h0;
        if (apb_acc && !PWRITE) begin
            unique case (PADDR)
                `OFS_CTRL:   PRDATA = {31'h0, en_q};
                `OFS_STATUS: PRDATA = {29'h0, ovf_q, pending, prog_en_q};
                `OFS_FUSE:   PRDATA = {8'h0, fuse_ex_q, fuse_hi_q, fuse_lo_q};
                `OFS_LOCK:   PRDATA = {26'h0, lock_q};
                default:     PRDATA = 32'h0;
            endcase
        end
    end

    // assertions
    property p_load_slot;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        ex_pop && ex_word[31:16] == {`OP_LOAD_PAGE, 8'h00} |=>
            pg_mask_q[$past(ex_word[15:13])] &&
            pg_data_q[$past(ex_word[15:13])] == $past(ex_word[7:0]);
    endproperty
    a_load_slot: assert property (p_load_slot)
        else $error("page slot not loaded");

    property p_commit_len;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        $rose(st_q == EX_COMMIT) |-> (st_q == EX_COMMIT) [*8] ##1
            (st_q == EX_WAIT && pg_mask_q == 8'h0);
    endproperty
    a_commit_len: assert property (p_commit_len)
        else $error("commit does not last eight cycles");

    property p_only_loaded;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        EE_WE_O |-> $past(pg_mask_q[cm_idx_q]) && $past(st_q == EX_COMMIT);
    endproperty
    a_only_loaded: assert property (p_only_loaded)
        else $error("unloaded page slot written");

    property p_lock_write;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        ex_pop && ex_word[31:24] == `OP_WRITE_MISC &&
        ex_word[23:21] == 3'b111 |=> lock_q == $past(ex_word[5:0]);
    endproperty
    a_lock_write: assert property (p_lock_write)
        else $error("lock bits not written");

    property p_ext_fuse;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        fuse_ex_q[7:2] == 6'h3f;
    endproperty
    a_ext_fuse: assert property (p_ext_fuse)
        else $error("extended fuse upper bits changed");

    property p_fuse_wait;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        ex_pop && ex_word[31:16] == {`OP_WRITE_MISC, `B2_FUSE_HIGH} |=>
            pending ##1 pending ##1 fuse_hi_q == $past(ex_word[7:0], 3);
    endproperty
    a_fuse_wait: assert property (p_fuse_wait)
        else $error("fuse write not pending");

    property p_miso_idle;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        !link_on |=> !MISO_O;
    endproperty
    a_miso_idle: assert property (p_miso_idle)
        else $error("output driven outside programming");

    property p_miso_fall;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        $changed(MISO_O) && link_on && $past(link_on) |-> $past(sck_fall);
    endproperty
    a_miso_fall: assert property (p_miso_fall)
        else $error("output changed away from falling edge");

    property p_count_wrap;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        word_done |=> bit_cnt_q == 6'h0;
    endproperty
    a_count_wrap: assert property (p_count_wrap)
        else $error("instruction is not four bytes");

    c_commit: cover property (@(posedge CORE_CLK_I) $rose(EE_WE_O));
    c_ovf:    cover property (@(posedge CORE_CLK_I) $rose(ovf_q));
    c_prog:   cover property (@(posedge CORE_CLK_I) $rose(prog_en_q));
endmodule : isp_decoder

// *** isp_prog_model.sv ***
// Purpose: programmer model on the far side of the serial link
// Assumes: serial clock half period of four core cycles
// Notes: the bench calls the tasks; sck rests low between frames
`timescale 1ns/10ps
module isp_prog_model (
    input  wire logic clk_i,
    input  wire logic miso_i,
    output logic      sck_o,
    output logic      mosi_o,
    output logic      prog_reset_n_o
);
    initial begin
        sck_o          = 1'b0;
        mosi_o         = 1'b0;
        prog_reset_n_o = 1'b1;
    end

    // pin driven to lvl and held four core edges before the next frame
    task automatic hold_reset(input logic lvl);
        @(posedge clk_i);
        prog_reset_n_o <= lvl;
        repeat (4) @(posedge clk_i);
    endtask : hold_reset

    // four bytes msb first
    task automatic xfer(input logic [31:0] tx,
                        output logic [31:0] rx);
        for (int i = 31; i >= 0; i--) begin
            @(posedge clk_i);
            sck_o  <= 1'b0;
            mosi_o <= tx[i];
            repeat (4) @(posedge clk_i);
            rx[i] = miso_i;
            sck_o <= 1'b1;
            repeat (3) @(posedge clk_i);
        end
        @(posedge clk_i);
        sck_o  <= 1'b0;
        // released line must not look like the last bit
        mosi_o <= ~tx[0];
        repeat (8) @(posedge clk_i);
    endtask : xfer
endmodule : isp_prog_model

// *** serial_isp_command_decoder_tb_top.sv ***
// Purpose: self-checking bench of the serial programming decoder
// Assumes: short wait parameters so pending outlasts one poll frame
// Notes: apb tasks for registers, programmer model for the link
`timescale 1ns/10ps
`include "isp_defines.svh"
module serial_isp_command_decoder_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sck, mosi, prog_rst_n, miso, ee_we;
    logic [10:0] ee_addr;
    logic [7:0]  ee_data;
    logic        psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, rx;
    logic [18:0] ee_log[$];
    int          fails = 0;
    int          n_checks = 0;
    logic [7:0]  fw_b2[3] = '{8'ha0, 8'ha8, 8'ha4};
    logic [7:0]  fr_b1[3] = '{8'h50, 8'h58, 8'h50};
    logic [7:0]  fr_b2[3] = '{8'h00, 8'h08, 8'h08};
    logic [7:0]  fv[3]    = '{8'h5a, 8'ha5, 8'hfe};
    logic [7:0]  fm[3]    = '{8'hff, 8'hff, 8'h03};

    always #25 clk = ~clk;

    isp_decoder #(.EE_WAIT(2000), .FUSE_WAIT(2000)) i_dut (
        .CORE_CLK_I(clk), .SYS_RST_I(rst), .SCK_I(sck), .MOSI_I(mosi),
        .PROG_RESET_N_I(prog_rst_n), .MISO_O(miso), .EE_WE_O(ee_we),
        .EE_ADDR_O(ee_addr), .EE_DATA_O(ee_data), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr));

    isp_prog_model i_prog (
        .clk_i(clk), .miso_i(miso), .sck_o(sck), .mosi_o(mosi),
        .prog_reset_n_o(prog_rst_n));

    always @(posedge clk) begin
        if (ee_we === 1'b1) begin
            ee_log.push_back({ee_addr, ee_data});
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        int k;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            check("pready", 32'h1, 32'h0);
            summarize();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // bounded polling until the pending bit clears
    task automatic wait_idle(input int bound);
        for (int k = 0; k < bound; k++) begin
            i_prog.xfer(32'hf0000000, rx);
            if (rx[0] === 1'b0) return;
        end
        check("pending", 32'h0, {31'h0, rx[0]});
        summarize();
    endtask : wait_idle

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, `OFS_CTRL, 32'h0);
        check("ctrl", 32'h1, {31'h0, rd[0]});
        check("ctrl err", 32'h0, {31'h0, err});
        apb(1'b0, `OFS_FUSE, 32'h0);
        check("fuse reset", 32'hffff, {16'h0, rd[15:0]});
        apb(1'b0, `OFS_LOCK, 32'h0);
        check("lock reset", 32'h3f, {26'h0, rd[5:0]});
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped err", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
        apb(1'b1, `OFS_CTRL, 32'h0);
        apb(1'b0, `OFS_CTRL, 32'h0);
        check("ctrl off", 32'h0, {31'h0, rd[0]});
        apb(1'b1, `OFS_CTRL, 32'h1);
        $display("test registers done");

        i_prog.xfer(32'hac530000, rx);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check("enable ignored", 32'h0, {31'h0, rd[0]});
        i_prog.hold_reset(1'b0);
        i_prog.xfer(32'hac530000, rx);
        check("echo", 32'h53, {24'h0, rx[15:8]});
        apb(1'b0, `OFS_STATUS, 32'h0);
        check("enabled", 32'h1, {31'h0, rd[0]});
        $display("test enable done");

        for (int i = 0; i < 3; i++) begin
            i_prog.xfer({8'hac, fw_b2[i], 8'h5c, fv[i]}, rx);
            i_prog.xfer(32'hf0000000, rx);
            check("poll busy", 32'h1, {31'h0, rx[0]});
            apb(1'b0, `OFS_STATUS, 32'h0);
            check("pending reg", 32'h1, {31'h0, rd[1]});
            wait_idle(20);
            i_prog.xfer({fr_b1[i], fr_b2[i], 8'h5c, 8'h00}, rx);
            check("fuse out", {24'h0, fv[i] & fm[i]},
                  {24'h0, rx[7:0] & fm[i]});
            apb(1'b0, `OFS_FUSE, 32'h0);
            check("fuse reg", {24'h0, fv[i] & fm[i]},
                  {24'h0, rd[i*8 +: 8] & fm[i]});
        end
        $display("test fuses done");

        i_prog.xfer(32'hace75cea, rx);
        wait_idle(20);
        i_prog.xfer(32'h58005c00, rx);
        check("lock out", 32'h2a, {26'h0, rx[5:0]});
        apb(1'b0, `OFS_LOCK, 32'h0);
        check("lock reg", 32'h2a, {26'h0, rd[5:0]});
        $display("test lock done");

        i_prog.xfer(32'hc1002011, rx);
        i_prog.xfer(32'hc100c066, rx);
        i_prog.xfer(32'hc22d9800, rx);
        wait_idle(20);
        check("slots written", 32'h2, ee_log.size());
        check("slot one", {13'h0, 8'hb3, 3'd1, 8'h11}, ee_log[0]);
        check("slot six", {13'h0, 8'hb3, 3'd6, 8'h66}, ee_log[1]);
        $display("test page done");

        // six writes without polling: the queue holds four
        for (int i = 1; i <= 6; i++) begin
            i_prog.xfer({24'haca05c, i[7:0]}, rx);
        end
        apb(1'b0, `OFS_STATUS, 32'h0);
        check("overflow", 32'h1, {31'h0, rd[2]});
        apb(1'b1, `OFS_STATUS, 32'h4);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check("overflow clr", 32'h0, {31'h0, rd[2]});
        wait_idle(60);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check("idle reg", 32'h0, {31'h0, rd[1]});
        i_prog.xfer(32'h50005c00, rx);
        check("last queued", 32'h05, {24'h0, rx[7:0]});
        $display("test queue done");
        summarize();
    end
endmodule : serial_isp_command_decoder_tb_top
